// ==== core/power_stage_protection_mode_ctrl.sv ====
// protection mode control for a stereo pwm power stage
`timescale 1ns/10ps
module power_stage_protection_mode_ctrl
	import protect_pkg::*;
#(
	parameter int RECOVERY_COUNT = protect_pkg::RECOVERY_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic pwm_drive_input_i,
	input wire logic reset_n_i,
	input wire logic [protect_pkg::NUM_HALF_BRIDGE-1:0] oc_high_side_i,
	input wire logic [protect_pkg::NUM_HALF_BRIDGE-1:0] oc_low_side_i,
	input wire logic overtemp_error_i,
	input wire logic gate_undervoltage_i,
	input wire logic protect_sel_strap_a_i,
	input wire logic protect_sel_strap_b_i,
	input wire logic output_config_strap_i,
	output logic hiz_o,
	output logic protect_latch_o,
	output logic fault_report_n_o,
	output logic fault_report_n_oe_o,
	output logic [1:0] protect_mode_o,
	output logic strap_reserved_o,
	output logic btl_mode_o
);
	localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(RECOVERY_COUNT / 2);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(RECOVERY_COUNT);

	// pin inputs: pwm, reset_n, and all error sources
	localparam int SW = 2 + 2 * NUM_HALF_BRIDGE + 2;
	logic [SW-1:0] pins_raw;
	logic [SW-1:0] pins_sync;
	logic [SW-1:0] pins_init;
	assign pins_raw = {pwm_drive_input_i, reset_n_i, oc_high_side_i, oc_low_side_i,
		overtemp_error_i, gate_undervoltage_i};
	assign pins_init = {2'h0, {(SW-2){1'b0}}};

	sync3 #(.W(SW)) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.en_i(clk_en_i),
		.d_i(pins_raw),
		.init_i(pins_init),
		.q_o(pins_sync)
	);

	wire pwm_s = pins_sync[SW-1];
	wire rst_n_s = pins_sync[SW-2];
	wire [NUM_HALF_BRIDGE-1:0] ochs_s = pins_sync[2*NUM_HALF_BRIDGE+1:NUM_HALF_BRIDGE+2];
	wire [NUM_HALF_BRIDGE-1:0] ocls_s = pins_sync[NUM_HALF_BRIDGE+1:2];
	wire ot_s = pins_sync[1];
	wire uv_s = pins_sync[0];

	// straps caught once after reset release, since they never move in use
	logic strap_taken_ff;
	logic [1:0] strap_ff;
	logic cfg_ff;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			strap_taken_ff <= 1'b0;
			strap_ff <= STRAP_LATCHING;
			cfg_ff <= OUTPUT_BTL;
		end else if (clk_en_i && !strap_taken_ff) begin
			strap_taken_ff <= 1'b1;
			strap_ff <= {protect_sel_strap_a_i, protect_sel_strap_b_i}; // see RL10
			cfg_ff <= output_config_strap_i;
		end
	end

	wire prot_mode_type mode = decode_mode(strap_ff); // see RL11
	wire mode_auto = (mode == AUTORECOVER_PROTECT_MODE);
	wire mode_latch = (mode == LATCHING_SHUTDOWN_MODE);
	wire mode_off = (mode == PROTECTION_OFF_TEST_MODE);

	// any error from either channel pair feeds one shared path
	wire any_error = (|ochs_s) | (|ocls_s) | ot_s | uv_s; // see RL13 see RL3
	wire err_live = any_error && !mode_off && strap_taken_ff; // see RL9

	// pwm rising edge drives the recovery counter
	logic pwm_d_ff;
	logic rst_n_d_ff;
	wire pwm_rise = pwm_s && !pwm_d_ff; // see RL2
	wire rst_fall = !rst_n_s && rst_n_d_ff;

	prot_state_type state_ff;
	prot_state_type nxt_state;
	logic latch_ff;
	logic nxt_latch;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	wire cnt_inc = pwm_rise && (state_ff == ST_LATCHED || state_ff == ST_HOLD_HIZ);
	wire [CNT_W-1:0] cnt_up = cnt_ff + CNT_W'(1);
	wire at_half = cnt_inc && (cnt_up == HALF_CNT); // see RL5
	wire at_full = cnt_inc && (cnt_up == FULL_CNT); // see RL6

	always_comb begin
		nxt_state = state_ff;
		nxt_latch = latch_ff;
		nxt_cnt = cnt_inc ? cnt_up : cnt_ff;
		if (!rst_n_s) begin
			nxt_state = ST_MUTED;
			if (rst_fall) begin
				nxt_latch = 1'b0; // see RL14 see RL8
			end
			nxt_cnt = '0;
		end else begin
			unique case (state_ff)
				ST_RUN: begin
					if (err_live) begin
						nxt_state = ST_LATCHED; // see RL4 see RL1 see RL7
						nxt_latch = 1'b1;
						nxt_cnt = '0;
					end
				end
				ST_LATCHED: begin
					if (mode_off) begin
						nxt_state = ST_RUN;
						nxt_latch = 1'b0;
					end else if (mode_auto && at_half) begin
						nxt_state = ST_HOLD_HIZ; // see RL5
						nxt_latch = 1'b0;
					end else if (!mode_auto) begin
						nxt_cnt = '0; // see RL7
					end
				end
				ST_HOLD_HIZ: begin
					if (at_full && err_live) begin
						nxt_state = ST_LATCHED; // see RL16
						nxt_latch = 1'b1;
						nxt_cnt = '0;
					end else if (at_full) begin
						nxt_state = ST_RUN; // see RL6 see RL1
						nxt_cnt = '0;
					end
				end
				ST_MUTED: begin
					nxt_state = ST_RUN; // see RL14
					nxt_cnt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= ST_MUTED;
			latch_ff <= 1'b0;
			cnt_ff <= '0;
			pwm_d_ff <= 1'b0;
			rst_n_d_ff <= 1'b0;
		end else if (clk_en_i) begin
			state_ff <= nxt_state;
			latch_ff <= nxt_latch;
			cnt_ff <= nxt_cnt;
			pwm_d_ff <= pwm_s;
			rst_n_d_ff <= rst_n_s;
		end
	end

	// fault pin is open drain; pulling low only in protection with reset high
	logic fault_ff;
	wire in_protect = (state_ff == ST_LATCHED) || (state_ff == ST_HOLD_HIZ);
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fault_ff <= 1'b0;
		end else if (clk_en_i) begin
			fault_ff <= in_protect && rst_n_s; // see RL15
		end
	end

	assign hiz_o = (state_ff != ST_RUN);
	assign protect_latch_o = latch_ff;
	assign fault_report_n_o = 1'b0;
	assign fault_report_n_oe_o = fault_ff;
	assign protect_mode_o = strap_ff;
	assign strap_reserved_o = (strap_ff != STRAP_LATCHING) || (cfg_ff != OUTPUT_BTL); // see RL12
	assign btl_mode_o = (cfg_ff == OUTPUT_BTL);

	// checks
	sequence err_in_run;
		state_ff == ST_RUN && rst_n_s && err_live;
	endsequence

	chk_error_latches: assert property (@(posedge clk_i) disable iff (reset_i) // see RL4
		clk_en_i and err_in_run |=> latch_ff && hiz_o && cnt_ff == '0)
		else $error("error did not set latch and hi-z");

	chk_off_no_hiz: assert property (@(posedge clk_i) disable iff (reset_i) // see RL9
		clk_en_i && mode_off && state_ff == ST_RUN && rst_n_s |=> !hiz_o)
		else $error("protection-off mode went hi-z");

	chk_latch_holds: assert property (@(posedge clk_i) disable iff (reset_i) // see RL7
		clk_en_i && mode_latch && state_ff == ST_LATCHED && rst_n_s |=> state_ff == ST_LATCHED)
		else $error("latching shutdown left without reset");

	chk_half_clears: assert property (@(posedge clk_i) disable iff (reset_i) // see RL5
		clk_en_i && rst_n_s && mode_auto && state_ff == ST_LATCHED && at_half
		|=> !latch_ff && hiz_o)
		else $error("half count did not clear latch with hi-z");

	chk_full_resumes: assert property (@(posedge clk_i) disable iff (reset_i) // see RL6
		clk_en_i && rst_n_s && state_ff == ST_HOLD_HIZ && at_full && !err_live |=> !hiz_o)
		else $error("full count did not resume switching");

	chk_relatch_fault: assert property (@(posedge clk_i) disable iff (reset_i) // see RL16
		clk_en_i && rst_n_s && state_ff == ST_HOLD_HIZ && at_full && err_live
		|=> latch_ff && cnt_ff == '0)
		else $error("persisting fault did not relatch");

	chk_reset_clears: assert property (@(posedge clk_i) disable iff (reset_i) // see RL14
		clk_en_i && rst_fall |=> !latch_ff && hiz_o)
		else $error("reset fall did not clear latch");

	chk_fault_pin: assert property (@(posedge clk_i) disable iff (reset_i) // see RL15
		clk_en_i && !rst_n_s |=> !fault_report_n_oe_o)
		else $error("fault pin pulled low while reset low");

	chk_count_pwm: assert property (@(posedge clk_i) disable iff (reset_i) // see RL2
		clk_en_i && rst_n_s && state_ff == ST_HOLD_HIZ && !pwm_rise |=> $stable(cnt_ff))
		else $error("counter moved without a pwm edge");
endmodule : power_stage_protection_mode_ctrl

// ==== core/protect_pkg.sv ====
// package with constants for the power stage protection mode control
// How it works
// RL1: autorecovery mode keeps all protection active; errors go hi-z, then recover alone.
// RL2: recovery delay counts input pwm cycles, not a fixed time base.
// RL3: one recovery counter serves both half-bridge channel pairs.
// RL4: an error sets the protection latch, forcing hi-z, and zeroes the counter.
// RL5: at half count the latch clears but outputs stay hi-z.
// RL6: at the full count of 512 pwm cycles switching resumes.
// RL7: latching mode holds hi-z after any error until reset is pulsed.
// RL8: controller recovers a latched shutdown by pulsing reset low then high.
// RL9: protection-off mode ignores all errors and never forces hi-z.
// RL10: protection mode is read from two strap pins.
// RL11: strap a=0, b=1 selects latching shutdown; other codes reserved.
// RL12: output config strap 0 selects bridge-tied load; 1 reserved.
// RL13: errors are overcurrent on any transistor, overtemperature, gate-supply undervoltage.
// RL14: falling reset edge clears the latch; rising reset resumes switching.
// RL15: fault output low in protection with reset high; forced high while reset low.
// RL16: fault still present at recovery end relatches and restarts the counter.
package protect_pkg;
	localparam int RECOVERY_CYCLES = 512;
	localparam int CNT_W = 10;
	localparam logic [1:0] STRAP_AUTORECOVER = 2'h0;
	localparam logic [1:0] STRAP_LATCHING = 2'h1;
	localparam logic [1:0] STRAP_PROTECT_OFF = 2'h2;
	localparam logic OUTPUT_BTL = 1'h0;
	localparam int NUM_HALF_BRIDGE = 4;

	typedef enum logic [2:0] {
		AUTORECOVER_PROTECT_MODE = 3'h1,
		LATCHING_SHUTDOWN_MODE = 3'h2,
		PROTECTION_OFF_TEST_MODE = 3'h4
	} prot_mode_type;

	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_LATCHED = 4'h2,
		ST_HOLD_HIZ = 4'h4,
		ST_MUTED = 4'h8
	} prot_state_type;

	function automatic prot_mode_type decode_mode(input logic [1:0] code);
		unique case (code)
			STRAP_LATCHING: decode_mode = LATCHING_SHUTDOWN_MODE;
			STRAP_PROTECT_OFF: decode_mode = PROTECTION_OFF_TEST_MODE;
			default: decode_mode = AUTORECOVER_PROTECT_MODE;
		endcase
	endfunction : decode_mode
endpackage : protect_pkg

// ==== core/sync3.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module sync3 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic en_i,
	input wire logic [W-1:0] d_i,
	input wire logic [W-1:0] init_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;
	logic [W-1:0] nxt_q;
	logic primed_ff;

	// a bit only changes once stage two and three agree
	assign nxt_q = primed_ff ? ((s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff))) : init_i;
	assign q_o = q_ff;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			q_ff <= '0;
			primed_ff <= 1'b0;
		end else if (en_i) begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff <= nxt_q;
			primed_ff <= 1'b1;
		end
	end
endmodule : sync3

// ==== sim/pwm_ctrl_model.sv ====
// far-side model: pwm source and reset pin controller
`timescale 1ns/10ps
module pwm_ctrl_model (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic release_i,
	output logic pwm_o,
	output logic reset_n_o
);
	logic [2:0] phase_ff;
	// held low when stopped, a steady high would drain the bootstrap
	always_ff @(posedge clk_i) begin
		phase_ff <= run_i ? phase_ff + 3'h1 : 3'h0;
	end
	assign pwm_o = phase_ff[2];
	// low then high recovers a latched shutdown
	assign reset_n_o = release_i;
endmodule : pwm_ctrl_model

// ==== sim/tb.sv ====
// self-checking bench for the protection mode control
`timescale 1ns/10ps
module tb;
	import protect_pkg::*;
	localparam int RC = 8;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic run = 1'b0;
	logic rel = 1'b0;
	logic en = 1'b1;
	logic pwm, rst_n, hiz, latch, fdat, foe, resv, btl;
	logic [3:0] oc_hi = 4'h0;
	logic [3:0] oc_lo = 4'h0;
	logic ot = 1'b0;
	logic uv = 1'b0;
	logic [2:0] strap = 3'h0;
	logic [1:0] mode;
	int err_count = 0;
	int tests_run = 0;
	int n;
	initial forever #2.5 clk_i = ~clk_i;
	pwm_ctrl_model model (.clk_i(clk_i), .run_i(run), .release_i(rel), .pwm_o(pwm),
		.reset_n_o(rst_n));
	power_stage_protection_mode_ctrl #(.RECOVERY_COUNT(RC)) DUT (
		.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(en), .pwm_drive_input_i(pwm),
		.reset_n_i(rst_n), .oc_high_side_i(oc_hi), .oc_low_side_i(oc_lo),
		.overtemp_error_i(ot), .gate_undervoltage_i(uv),
		.protect_sel_strap_a_i(strap[2]), .protect_sel_strap_b_i(strap[1]),
		.output_config_strap_i(strap[0]), .hiz_o(hiz), .protect_latch_o(latch),
		.fault_report_n_o(fdat), .fault_report_n_oe_o(foe), .protect_mode_o(mode),
		.strap_reserved_o(resv), .btl_mode_o(btl));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	// bounded wait on latch (0) or hiz (1), counting pwm rises meanwhile
	task automatic wait_on(input bit which, input logic val);
		logic last;
		n = 0;
		last = pwm;
		for (int i = 0; i < 4000; i++) begin
			@(negedge clk_i);
			if (pwm && !last) begin
				n++;
			end
			last = pwm;
			if ((which ? hiz : latch) === val) begin
				return;
			end
		end
		err_count++;
		close_out();
	endtask : wait_on
	// pwm rises between steps, sync latency allows one either way
	task automatic near_half;
		check({7'h0, n >= RC / 2 - 1 && n <= RC / 2 + 1}, 8'h01);
	endtask : near_half
	task automatic start(input logic [2:0] s);
		@(negedge clk_i);
		strap = s;
		reset_i = 1'b1;
		rel = 1'b0;
		run = 1'b1;
		repeat (2) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (8) @(negedge clk_i);
		check({7'h0, hiz}, 8'h01);
		check({6'h0, mode}, {6'h0, s[2:1]});
		check({7'h0, resv}, {7'h0, s[2:1] != 2'h1 || s[0]});
		check({7'h0, btl}, {7'h0, !s[0]});
		rel = 1'b1;
		wait_on(1'b1, 1'b0);
	endtask : start
	initial begin
		start(3'h0);
		oc_lo = 4'h8;
		wait_on(1'b0, 1'b1);
		check({7'h0, hiz}, 8'h01);
		repeat (4) @(negedge clk_i);
		check({6'h0, foe, fdat}, 8'h02);
		oc_lo = 4'h0;
		wait_on(1'b0, 1'b0);
		near_half();
		check({7'h0, hiz}, 8'h01);
		wait_on(1'b1, 1'b0);
		near_half();
		repeat (4) @(negedge clk_i);
		check({7'h0, foe}, 8'h00);
		$display("test autorecovery done");
		// fault held past the full count, other channel pair
		oc_hi = 4'h1;
		wait_on(1'b0, 1'b1);
		wait_on(1'b0, 1'b0);
		ot = 1'b1;
		wait_on(1'b0, 1'b1);
		near_half();
		check({7'h0, hiz}, 8'h01);
		oc_hi = 4'h0;
		ot = 1'b0;
		wait_on(1'b1, 1'b0);
		$display("test relatch done");
		start(3'h2);
		uv = 1'b1;
		wait_on(1'b0, 1'b1);
		uv = 1'b0;
		repeat (RC * 24) @(negedge clk_i);
		check({6'h0, hiz, latch}, 8'h03);
		rel = 1'b0;
		wait_on(1'b0, 1'b0);
		repeat (4) @(negedge clk_i);
		check({6'h0, hiz, foe}, 8'h02);
		rel = 1'b1;
		wait_on(1'b1, 1'b0);
		$display("test latching done");
		// reserved codes: 11 runs as autorecovery, config 1 flagged
		start(3'h7);
		// a frozen block must not see an error that comes and goes meanwhile
		en = 1'b0;
		uv = 1'b1;
		repeat (40) @(negedge clk_i);
		check({6'h0, hiz, latch}, 8'h00);
		uv = 1'b0;
		en = 1'b1;
		repeat (40) @(negedge clk_i);
		check({6'h0, hiz, latch}, 8'h00);
		$display("test strap decode and freeze done");
		start(3'h4);
		oc_hi = 4'hF;
		ot = 1'b1;
		uv = 1'b1;
		repeat (RC * 24) @(negedge clk_i);
		check({5'h0, hiz, latch, foe}, 8'h00);
		$display("test protection off done");
		close_out();
	end
endmodule : tb
